/* rtl/bsbx_defines.vh */
/*
 * constants for the branch, skip, bit-set and shift execution block.
 * assumes a 16-bit instruction word and an 8-bit status register.
 */
`ifndef BSBX_DEFINES_VH
`define BSBX_DEFINES_VH

// status register bit positions
`define BSBX_FLAG_C       3'd0
`define BSBX_FLAG_Z       3'd1
`define BSBX_FLAG_N       3'd2
`define BSBX_FLAG_V       3'd3
`define BSBX_FLAG_S       3'd4
`define BSBX_FLAG_H       3'd5
`define BSBX_FLAG_T       3'd6
`define BSBX_FLAG_I       3'd7

// operation codes presented on op_code
`define BSBX_OP_NOP                  5'h00
`define BSBX_OP_SKIP_REG_BIT_CLEAR   5'h01
`define BSBX_OP_SKIP_REG_BIT_SET     5'h02
`define BSBX_OP_SKIP_IO_BIT_CLEAR    5'h03
`define BSBX_OP_SKIP_IO_BIT_SET      5'h04
`define BSBX_OP_BRANCH_FLAG_SET      5'h05
`define BSBX_OP_BRANCH_FLAG_CLEAR    5'h06
`define BSBX_OP_SET_IO_BIT           5'h07
`define BSBX_OP_CLEAR_IO_BIT         5'h08
`define BSBX_OP_SHIFT_LEFT_LOGICAL   5'h09
`define BSBX_OP_SHIFT_RIGHT_LOGICAL  5'h0a

// reset values
`define BSBX_PC_RESET     16'h0000
`define BSBX_STATUS_REGISTER_RESET   8'h00
`define BSBX_IO_RESET     8'h00

// cycle counts: extra wait cycles after the issue cycle
`define BSBX_WAIT_TAKEN_BR  2'd1
`define BSBX_WAIT_SKIP_1W   2'd1
`define BSBX_WAIT_SKIP_2W   2'd2
`define BSBX_WAIT_IO_BIT    2'd1

`endif

/* rtl/bsbx_io_mem.v */
/*
 * small i/o register file, 32 bytes, one read port with registered data
 * and one write port. assumes the caller holds the address stable for
 * the read cycle it wants.
 */
`timescale 1ns/1ps
`include "bsbx_defines.vh"

module bsbx_io_mem (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire [4:0] rd_addr,
    output reg  [7:0] rd_data,
    input  wire       wr_en,
    input  wire [4:0] wr_addr,
    input  wire [7:0] wr_data
);
    reg [7:0] mem_reg [0:31];
    genvar i;

    generate
        for (i = 0; i < 32; i = i + 1) begin : g_byte
            localparam [4:0] BYTE_ADDR = i;
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[i] <= `BSBX_IO_RESET;
                end else if (wr_en && wr_addr == BYTE_ADDR) begin
                    mem_reg[i] <= wr_data;
                end
            end
        end
    endgenerate

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `BSBX_IO_RESET;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule

/* rtl/bsbx_exec.v */
/*
 * execution unit for conditional skips, relative branches on status flags,
 * single i/o bit set/clear and logical shifts of an 8-bit core.
 * assumes a decoder outside presents one operation at a time with
 * op_valid while op_ready is high; the working register value arrives
 * on reg_data and results leave on reg_wr_*. one clock, async reset.
 */
`timescale 1ns/1ps
`include "bsbx_defines.vh"

// Functional notes
// - skip next instruction when working register bit b is zero
// - skip next instruction when working register bit b is one, flags kept
// - skip next instruction when i/o register bit b reads zero, flags kept
// - skip next instruction when i/o register bit b reads one, flags kept
// - generic flag branch to pc+k+1 on status bit s set or clear
// - equal / not-equal branch on zero flag
// - carry branches: same-or-higher/clear on c=0, lower/set on c=1
// - minus branches on n=1, plus branches on n=0
// - signed greater-or-equal branches when n xor v is 0
// - signed less-than branches when n xor v is 1
// - half-carry branches on h set or clear
// - transfer-flag branches on t set or clear
// - overflow branches on v set or clear
// - interrupt-state branches on i set or clear
// - set i/o bit writes one to bit b, two cycles, flags kept
// - clear i/o bit writes zero to bit b, two cycles, flags kept
// - shift left: zero into bit 0, update z c n v, one cycle
// - shift right: zero into bit 7, update z c n v, one cycle
module bsbx_exec (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        op_valid,
    input  wire [4:0]  op_code,
    input  wire [2:0]  op_bit,
    input  wire [4:0]  op_io_addr,
    input  wire [6:0]  op_offset,
    input  wire        op_next_two_word,
    input  wire [7:0]  reg_data,
    input  wire [7:0]  status_register_wr_data,
    input  wire        status_register_wr_en,
    output reg         op_ready,
    output reg  [15:0] pc_out,
    output reg  [7:0]  status_register_out,
    output reg  [7:0]  reg_wr_data,
    output reg         reg_wr_en,
    output reg         op_done
);
    localparam ST_IDLE = 3'b001;
    localparam ST_IORD = 3'b010;
    localparam ST_WAIT = 3'b100;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [15:0] pc_reg;
    reg  [15:0] pc_next;
    reg  [7:0]  status_register_reg;
    reg  [7:0]  status_register_next;
    reg  [1:0]  wait_reg;
    reg  [1:0]  wait_next;
    reg  [4:0]  code_reg;
    reg  [2:0]  bit_reg;
    reg  [4:0]  addr_reg;
    reg         two_word_reg;
    reg  [7:0]  res_next;
    reg         res_wr_next;
    reg         done_next;
    reg         io_wr_en;
    reg  [7:0]  io_wr_data;
    reg         skip;
    reg         take;
    reg         bit_val;
    wire [7:0]  io_rd_data;
    wire [15:0] pc_seq;
    wire [15:0] pc_branch;

    assign pc_seq    = pc_reg + 16'h0001;
    // signed word displacement, sign-extended to the pc width
    assign pc_branch = pc_reg + {{9{op_offset[6]}}, op_offset} + 16'h0001;

    // read address is taken from the op directly so data lands one cycle later
    bsbx_io_mem bsbx_io_mem_i (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .rd_addr (state_reg == ST_IDLE ? op_io_addr : addr_reg),
        .rd_data (io_rd_data),
        .wr_en   (io_wr_en),
        .wr_addr (addr_reg),
        .wr_data (io_wr_data)
    );

    always @* begin
        state_next  = state_reg;
        pc_next     = pc_reg;
        status_register_next   = status_register_reg;
        wait_next   = wait_reg;
        res_next    = 8'h00;
        res_wr_next = 1'b0;
        done_next   = 1'b0;
        io_wr_en    = 1'b0;
        io_wr_data  = io_rd_data;
        skip        = 1'b0;
        take        = 1'b0;
        bit_val     = 1'b0;
        // external flag writes from the rest of the core; own updates override
        if (status_register_wr_en) begin
            status_register_next = status_register_wr_data;
        end
        case (state_reg)
            ST_IDLE: begin
                if (op_valid) begin
                    case (op_code)
                        `BSBX_OP_SKIP_REG_BIT_CLEAR, `BSBX_OP_SKIP_REG_BIT_SET: begin
                            bit_val = reg_data[op_bit];
                            skip    = (op_code == `BSBX_OP_SKIP_REG_BIT_SET) ?
                                      bit_val : !bit_val;
                            pc_next = pc_seq;
                            if (skip) begin
                                // pc walks over the skipped word(s)
                                pc_next    = op_next_two_word ? pc_reg + 16'h0003 :
                                                                pc_reg + 16'h0002;
                                wait_next  = op_next_two_word ? `BSBX_WAIT_SKIP_2W :
                                                                `BSBX_WAIT_SKIP_1W;
                                state_next = ST_WAIT;
                            end else begin
                                done_next = 1'b1;
                            end
                        end
                        `BSBX_OP_SKIP_IO_BIT_CLEAR, `BSBX_OP_SKIP_IO_BIT_SET,
                        `BSBX_OP_SET_IO_BIT, `BSBX_OP_CLEAR_IO_BIT: begin
                            state_next = ST_IORD;
                        end
                        `BSBX_OP_BRANCH_FLAG_SET, `BSBX_OP_BRANCH_FLAG_CLEAR: begin
                            // named branches map onto s: z c
                            // n s=n^v h
                            // t v i
                            bit_val = status_register_reg[op_bit];
                            take    = (op_code == `BSBX_OP_BRANCH_FLAG_SET) ?
                                      bit_val : !bit_val;
                            if (take) begin
                                pc_next    = pc_branch;
                                wait_next  = `BSBX_WAIT_TAKEN_BR;
                                state_next = ST_WAIT;
                            end else begin
                                pc_next   = pc_seq;
                                done_next = 1'b1;
                            end
                        end
                        `BSBX_OP_SHIFT_LEFT_LOGICAL: begin
                            res_next    = {reg_data[6:0], 1'b0};
                            res_wr_next = 1'b1;
                            status_register_next[`BSBX_FLAG_C] = reg_data[7];
                            status_register_next[`BSBX_FLAG_Z] = (res_next == 8'h00);
                            status_register_next[`BSBX_FLAG_N] = res_next[7];
                            status_register_next[`BSBX_FLAG_V] = res_next[7] ^ reg_data[7];
                            status_register_next[`BSBX_FLAG_S] = res_next[7] ^
                                                      (res_next[7] ^ reg_data[7]);
                            status_register_next[`BSBX_FLAG_H] = reg_data[3];
                            pc_next   = pc_seq;
                            done_next = 1'b1;
                        end
                        `BSBX_OP_SHIFT_RIGHT_LOGICAL: begin
                            res_next    = {1'b0, reg_data[7:1]};
                            res_wr_next = 1'b1;
                            status_register_next[`BSBX_FLAG_C] = reg_data[0];
                            status_register_next[`BSBX_FLAG_Z] = (res_next == 8'h00);
                            status_register_next[`BSBX_FLAG_N] = 1'b0;
                            // v = n xor c with n forced low
                            status_register_next[`BSBX_FLAG_V] = reg_data[0];
                            status_register_next[`BSBX_FLAG_S] = reg_data[0];
                            pc_next   = pc_seq;
                            done_next = 1'b1;
                        end
                        default: begin
                            pc_next   = pc_seq;
                            done_next = 1'b1;
                        end
                    endcase
                end
            end
            ST_IORD: begin
                // limitation: the registered i/o read costs a cycle, so an untaken
                // i/o skip takes two cycles instead of one
                bit_val = io_rd_data[bit_reg];
                case (code_reg)
                    `BSBX_OP_SET_IO_BIT: begin
                        io_wr_data          = io_rd_data;
                        io_wr_data[bit_reg] = 1'b1;
                        io_wr_en            = 1'b1;
                        pc_next             = pc_seq;
                        done_next           = 1'b1;
                        state_next          = ST_IDLE;
                    end
                    `BSBX_OP_CLEAR_IO_BIT: begin
                        io_wr_data          = io_rd_data;
                        io_wr_data[bit_reg] = 1'b0;
                        io_wr_en            = 1'b1;
                        pc_next             = pc_seq;
                        done_next           = 1'b1;
                        state_next          = ST_IDLE;
                    end
                    default: begin
                        skip = (code_reg == `BSBX_OP_SKIP_IO_BIT_SET) ?
                               bit_val : !bit_val;
                        if (skip) begin
                            pc_next    = two_word_reg ? pc_reg + 16'h0003 :
                                                        pc_reg + 16'h0002;
                            wait_next  = two_word_reg ? `BSBX_WAIT_SKIP_1W :
                                                        2'd0;
                            state_next = two_word_reg ? ST_WAIT : ST_IDLE;
                            done_next  = !two_word_reg;
                        end else begin
                            pc_next    = pc_seq;
                            done_next  = 1'b1;
                            state_next = ST_IDLE;
                        end
                    end
                endcase
            end
            ST_WAIT: begin
                wait_next = wait_reg - 2'd1;
                if (wait_reg == 2'd1) begin
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            pc_reg       <= `BSBX_PC_RESET;
            status_register_reg     <= `BSBX_STATUS_REGISTER_RESET;
            wait_reg     <= 2'd0;
            code_reg     <= `BSBX_OP_NOP;
            bit_reg      <= 3'd0;
            addr_reg     <= 5'd0;
            two_word_reg <= 1'b0;
            op_ready     <= 1'b1;
            pc_out       <= `BSBX_PC_RESET;
            status_register_out     <= `BSBX_STATUS_REGISTER_RESET;
            reg_wr_data  <= 8'h00;
            reg_wr_en    <= 1'b0;
            op_done      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            pc_reg       <= pc_next;
            status_register_reg     <= status_register_next;
            wait_reg     <= wait_next;
            if (state_reg == ST_IDLE && op_valid) begin
                code_reg     <= op_code;
                bit_reg      <= op_bit;
                addr_reg     <= op_io_addr;
                two_word_reg <= op_next_two_word;
            end
            op_ready     <= (state_next == ST_IDLE);
            pc_out       <= pc_next;
            status_register_out     <= status_register_next;
            reg_wr_data  <= res_next;
            reg_wr_en    <= res_wr_next;
            op_done      <= done_next;
        end
    end
endmodule

/* verification/bsbx_exec_asserts.sv */
/* concurrent checks for the branch, skip, i/o bit and shift unit.
   assumes it is bound to bsbx_exec and sees only that module's ports. */
`timescale 1ns/1ps
`include "bsbx_defines.vh"
module bsbx_exec_chk (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        op_valid,
    input wire [4:0]  op_code,
    input wire [2:0]  op_bit,
    input wire [4:0]  op_io_addr,
    input wire [6:0]  op_offset,
    input wire        op_next_two_word,
    input wire [7:0]  reg_data,
    input wire [7:0]  status_register_wr_data,
    input wire        status_register_wr_en,
    input wire        op_ready,
    input wire [15:0] pc_out,
    input wire [7:0]  status_register_out,
    input wire [7:0]  reg_wr_data,
    input wire        reg_wr_en,
    input wire        op_done
);
    wire       take = op_valid && op_ready;
    wire       hit  = status_register_out[op_bit] == (op_code == `BSBX_OP_BRANCH_FLAG_SET);
    wire       rhit = reg_data[op_bit] == (op_code == `BSBX_OP_SKIP_REG_BIT_SET);
    wire       br   = take && (op_code == 5'h05 || op_code == 5'h06);
    wire       sk   = take && (op_code == 5'h01 || op_code == 5'h02);
    reg [15:0] base_reg;
    reg [15:0] tgt_reg;
    reg [7:0]  rd_reg;
    // operands are latched at the take edge so checks do not depend on held inputs
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_reg <= 16'h0000;
            tgt_reg  <= 16'h0000;
            rd_reg   <= 8'h00;
        end else if (take) begin
            base_reg <= pc_out;
            tgt_reg  <= pc_out + {{9{op_offset[6]}}, op_offset} + 16'h0001;
            rd_reg   <= reg_data;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wait1;
        !op_done ##1 op_done;
    endsequence
    sequence s_wait2;
        !op_done [*2] ##1 op_done;
    endsequence
    AST_BR_TAKEN: assert property (br && hit |=> s_wait1 ##0 pc_out == tgt_reg)
        else $error("taken branch target or timing wrong");
    AST_BR_NOT: assert property (br && !hit |=> op_done && pc_out == base_reg + 16'h0001)
        else $error("untaken branch not one cycle to next word");
    AST_SKIP_ONE: assert property (
        sk && rhit && !op_next_two_word |=> s_wait1 ##0 pc_out == base_reg + 16'h0002)
        else $error("one word skip wrong");
    AST_SKIP_TWO: assert property (
        sk && rhit && op_next_two_word |=> s_wait2 ##0 pc_out == base_reg + 16'h0003)
        else $error("two word skip wrong");
    AST_SKIP_NOT: assert property (
        sk && !rhit |=> op_done && pc_out == base_reg + 16'h0001 && $stable(status_register_out))
        else $error("untaken skip wrong");
    AST_IO_BIT: assert property (
        take && (op_code == 5'h07 || op_code == 5'h08)
        |=> s_wait1 ##0 status_register_out == $past(status_register_out, 2))
        else $error("i/o bit op not two cycles or flags moved");
    AST_SHL: assert property (take && op_code == 5'h09 |=> op_done && reg_wr_en
        && reg_wr_data == {rd_reg[6:0], 1'b0} && status_register_out[0] == rd_reg[7])
        else $error("shift left result wrong");
    AST_SHR: assert property (take && op_code == 5'h0a |=> op_done && reg_wr_en
        && reg_wr_data == {1'b0, rd_reg[7:1]}
        && status_register_out[2:0] == {1'b0, rd_reg[7:1] == 7'h00, rd_reg[0]})
        else $error("shift right result wrong");
endmodule
bind bsbx_exec bsbx_exec_chk bsbx_exec_chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_bit(op_bit), .op_io_addr(op_io_addr), .op_offset(op_offset),
    .op_next_two_word(op_next_two_word), .reg_data(reg_data), .status_register_wr_data(status_register_wr_data),
    .status_register_wr_en(status_register_wr_en), .op_ready(op_ready), .pc_out(pc_out), .status_register_out(status_register_out),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .op_done(op_done)
);

/* verification/tb.sv */
/* self-checking bench for bsbx_exec: branches, skips, i/o bit ops, shifts.
   assumes the design and the checker are compiled before it. */
`timescale 1ns/1ps
`include "bsbx_defines.vh"
module tb;
    localparam [4:0] SIC = `BSBX_OP_SKIP_IO_BIT_CLEAR;
    localparam [4:0] SIS = `BSBX_OP_SKIP_IO_BIT_SET;
    localparam [47:0] SHV = 48'h81_00_80_01_48_fe;
    reg         sys_clk;
    reg         rst_n;
    reg         op_valid;
    reg  [4:0]  op_code;
    reg  [2:0]  op_bit;
    reg  [4:0]  op_io_addr;
    reg  [6:0]  op_offset;
    reg         op_next_two_word;
    reg  [7:0]  reg_data;
    reg  [7:0]  status_register_wr_data;
    reg         status_register_wr_en;
    wire        op_ready;
    wire [15:0] pc_out;
    wire [7:0]  status_register_out;
    wire [7:0]  reg_wr_data;
    wire        reg_wr_en;
    wire        op_done;
    reg  [7:0]  status_register_exp;
    reg  [7:0]  v;
    reg  [4:0]  opc;
    reg  [6:0]  k;
    reg  [4:0]  a;
    reg  [2:0]  b;
    reg  [15:0] e;
    reg         t;
    integer     i;
    integer     failures;
    integer     compares;

    bsbx_exec bsbx_exec_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .op_bit(op_bit), .op_io_addr(op_io_addr), .op_offset(op_offset),
        .op_next_two_word(op_next_two_word), .reg_data(reg_data),
        .status_register_wr_data(status_register_wr_data), .status_register_wr_en(status_register_wr_en), .op_ready(op_ready),
        .pc_out(pc_out), .status_register_out(status_register_out), .reg_wr_data(reg_wr_data),
        .reg_wr_en(reg_wr_en), .op_done(op_done)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task report_and_stop;
        begin
            if (failures == 0 && compares > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("MISMATCH time=%0t seen=%h expected=%h", $time, seen, exp);
            end
        end
    endtask

    task set_status_register(input [7:0] val);
        begin
            @(posedge sys_clk);
            status_register_wr_en   <= 1'b1;
            status_register_wr_data <= val;
            @(posedge sys_clk);
            status_register_wr_en <= 1'b0;
            status_register_exp = val;
        end
    endtask

    // one operation; counts edges from the take edge up to op_done
    task run_op(input [4:0] c, input [2:0] bit_sel, input [4:0] adr, input [6:0] off,
                input tw, input [7:0] rd, input [15:0] cyc, input [15:0] dpc,
                input [7:0] rexp);
        reg [15:0] pc0;
        reg [15:0] n;
        begin
            pc0 = pc_out;
            n = 16'd0;
            @(posedge sys_clk);
            op_valid         <= 1'b1;
            op_code          <= c;
            op_bit           <= bit_sel;
            op_io_addr       <= adr;
            op_offset        <= off;
            op_next_two_word <= tw;
            reg_data         <= rd;
            @(posedge sys_clk);
            op_valid <= 1'b0;
            // one-cycle ops raise op_done at the take edge itself
            #1;
            n = 16'd1;
            while (n < 16'd8 && op_done !== 1'b1) begin
                @(posedge sys_clk);
                #1;
                n = n + 16'd1;
            end
            chk(n, cyc);
            chk(pc_out, pc0 + dpc);
            chk({8'h00, status_register_out}, {8'h00, status_register_exp});
            chk({15'h0000, op_ready}, 16'h0001);
            if (c == `BSBX_OP_SHIFT_LEFT_LOGICAL || c == `BSBX_OP_SHIFT_RIGHT_LOGICAL)
                chk({7'h00, reg_wr_en, reg_wr_data}, {7'h00, 1'b1, rexp});
        end
    endtask

    // watchdog far above the few hundred cycles the sequence needs
    initial begin
        #100000;
        failures = failures + 1;
        report_and_stop;
    end

    initial begin
        failures = 0;
        compares = 0;
        rst_n = 1'b0;
        op_valid = 1'b0;
        op_code = 5'h00;
        op_bit = 3'h0;
        op_io_addr = 5'h00;
        op_offset = 7'h00;
        op_next_two_word = 1'b0;
        reg_data = 8'h00;
        status_register_wr_data = 8'h00;
        status_register_wr_en = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        // other flag bits opposite the tested one, so a wrong bit select shows
        for (i = 0; i < 32; i = i + 1) begin
            v = 8'h01 << i[2:0];
            set_status_register(i[3] ? v : ~v);
            k = i[0] ? 7'h40 : 7'h3f;
            t = i[3] ^ i[4];
            e = t ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001;
            opc = i[4] ? 5'h06 : 5'h05;
            run_op(opc, i[2:0], 5'h00, k, 1'b0, 8'h00, 16'd1 + t, e, 8'h00);
        end
        set_status_register(8'ha5);
        for (i = 0; i < 16; i = i + 1) begin
            v = i[3] ? 8'h01 << i[2:0] : ~(8'h01 << i[2:0]);
            t = i[1];
            e = i[3] ? 16'd1 : 16'd2 + t;
            run_op(5'h01, i[2:0], 5'h00, 7'h00, t, v, e, e, 8'h00);
            e = i[3] ? 16'd2 + t : 16'd1;
            run_op(5'h02, i[2:0], 5'h00, 7'h00, t, v, e, e, 8'h00);
        end
        for (i = 0; i < 8; i = i + 1) begin
            b = i[2:0];
            a = {b, 2'b01};
            t = b[0];
            e = 16'd2 + t;
            run_op(5'h07, b, a, 7'h00, 1'b0, 8'h00, 16'd2, 16'd1, 8'h00);
            run_op(SIS, b, a, 7'h00, t, 8'h00, e, e, 8'h00);
            run_op(SIC, b, a + 5'h01, 7'h00, 1'b0, 8'h00, 16'd2, 16'd2, 8'h00);
            run_op(5'h07, b ^ 3'h1, a, 7'h00, 1'b0, 8'h00, 16'd2, 16'd1, 8'h00);
            run_op(5'h08, b, a, 7'h00, 1'b0, 8'h00, 16'd2, 16'd1, 8'h00);
            run_op(SIC, b, a, 7'h00, 1'b1, 8'h00, 16'd3, 16'd3, 8'h00);
            run_op(SIS, b ^ 3'h1, a, 7'h00, 1'b0, 8'h00, 16'd2, 16'd2, 8'h00);
            run_op(SIS, b, a, 7'h00, 1'b0, 8'h00, 16'd2, 16'd1, 8'h00);
        end
        for (i = 0; i < 6; i = i + 1) begin
            v = SHV[i * 8 +: 8];
            set_status_register(8'hc0);
            status_register_exp = {2'b11, v[3], v[7], v[7] ^ v[6], v[6], v[6:0] == 7'h00, v[7]};
            run_op(5'h09, 3'h0, 5'h00, 7'h00, 1'b0, v, 16'd1, 16'd1, {v[6:0], 1'b0});
            set_status_register(8'hc0);
            status_register_exp = {3'b110, v[0], v[0], 1'b0, v[7:1] == 7'h00, v[0]};
            run_op(5'h0a, 3'h0, 5'h00, 7'h00, 1'b0, v, 16'd1, 16'd1, {1'b0, v[7:1]});
            run_op(5'h00, 3'h0, 5'h00, 7'h00, 1'b0, v, 16'd1, 16'd1, 8'h00);
        end
        report_and_stop;
    end
endmodule
